// File: hw/fcp_loader.sv
`default_nettype none
module fcp_loader
    import fcp_pkg::*;
#(
    parameter int CLEAR_CYCLES = 64,
    parameter int FETCH_WAIT   = 4
) (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                cfg_clock,
    input  wire logic                select_low_n,
    input  wire logic                select_high,
    input  wire logic                write_strobe_n,
    input  wire logic                read_strobe_n,
    input  wire logic [BYTE_W-1:0]   cfg_byte_bus_in,
    output var  logic [BYTE_W-1:0]   cfg_byte_bus_out,
    output var  logic                cfg_byte_bus_oe,
    input  wire logic [1:0]          mode_pins,
    input  wire logic                init_in,
    output var  logic                init_out,
    output var  logic                init_oe,
    input  wire logic                cfg_error,
    input  wire logic                cfg_complete,
    output var  logic                cfg_active_high_flag,
    output var  logic                cfg_active_high_flag_oe,
    output var  logic                cfg_active_low_flag,
    output var  logic                cfg_active_low_flag_oe,
    output var  logic                ready_busy,
    output var  logic [ADDR_W-1:0]   memory_fetch_addr,
    output var  logic                memory_fetch_addr_oe,
    input  wire logic                serial_in,
    output var  logic                serial_out,
    output var  logic                serial_out_oe,
    output var  logic                stream_bit,
    output var  logic                stream_valid,
    output var  logic                user_release
);

    // Pin synchronisers, main clock
    logic [16:0]       pin_a;
    logic [16:0]       pin_b;
    logic              sel_n_s;
    logic              sel_h_s;
    logic              ws_n_s;
    logic              rs_n_s;
    logic              init_s;
    logic              err_s;
    logic              done_s;
    logic [1:0]        mode_s;
    logic [BYTE_W-1:0] bus_s;

    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_a <= {SYNC_IDLE_HI, SYNC_IDLE_LO};
            pin_b <= {SYNC_IDLE_HI, SYNC_IDLE_LO};
        end else begin
            pin_a <= {select_low_n, select_high, write_strobe_n,
                      read_strobe_n, init_in, cfg_error, cfg_complete,
                      mode_pins, cfg_byte_bus_in};
            pin_b <= pin_a;
        end
    end

    assign {sel_n_s, sel_h_s, ws_n_s, rs_n_s, init_s, err_s, done_s,
            mode_s, bus_s} = pin_b;

    // Main sequencer
    fcp_state_t        state;
    fcp_mode_t         mode;
    logic [CNT_W-1:0]  cnt;
    logic              is_master;

    assign is_master = (mode_s == MD_MASTER_SER)
                    || (mode_s == MD_MASTER_PAR);

    logic in_full;
    logic ack_b;
    logic busy_i;

    assign busy_i = in_full || ack_b;

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= ST_CLEAR;
            mode  <= MD_SLAVE_SER;
            cnt   <= '0;
        end else begin
            case (state)
                ST_CLEAR: begin
                    if (cnt == CNT_W'(CLEAR_CYCLES - 1)) begin
                        state <= ST_WAIT;
                        cnt   <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_WAIT: begin
                    // Straps caught as the wait ends
                    if (init_s) begin
                        mode  <= fcp_mode_t'(mode_s);
                        cnt   <= '0;
                        state <= is_master ? ST_HOLD : ST_CONFIG;
                    end
                end
                ST_HOLD: begin
                    if (!init_s) begin
                        state <= ST_WAIT;
                    end else if (cnt == CNT_W'(MASTER_WAIT_CYC - 1)) begin
                        state <= ST_CONFIG;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_CONFIG: begin
                    if (done_s && !busy_i) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_DONE;
                end
                default: begin
                    state <= ST_CLEAR;
                end
            endcase
        end
    end

    // Host strobes
    logic selected;
    logic wr_act;
    logic wr_prev;
    logic wr_end;
    logic rd_act;
    logic periph;
    logic [BYTE_W-1:0] cap;

    assign selected = !sel_n_s && sel_h_s;
    assign periph   = (state == ST_CONFIG) && (mode == MD_PERIPH);
    assign wr_act   = selected && !ws_n_s && periph;
    assign wr_end   = wr_prev && !wr_act;
    assign rd_act   = selected && !rs_n_s && ws_n_s && periph;

    // Data tracks the strobe through the same synchroniser depth
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_prev <= 1'b0;
            cap     <= '0;
        end else begin
            wr_prev <= wr_act;
            if (wr_act) begin
                cap <= bus_s;
            end
        end
    end

    // Master parallel fetch
    logic [3:0]        fetch_cnt;
    logic              fetch_go;
    logic              mpar;

    assign mpar     = (state == ST_CONFIG) && (mode == MD_MASTER_PAR);
    assign fetch_go = mpar && !busy_i
                   && (fetch_cnt == 4'(FETCH_WAIT - 1));

    always_ff @(posedge mclk) begin
        if (reset) begin
            fetch_cnt         <= '0;
            memory_fetch_addr <= '0;
        end else begin
            if (!mpar || busy_i || fetch_go) begin
                fetch_cnt <= '0;
            end else begin
                fetch_cnt <= fetch_cnt + 1'b1;
            end
            if (fetch_go) begin
                memory_fetch_addr <= memory_fetch_addr + 1'b1;
            end
        end
    end

    // Input buffer and handshake toward the shifter
    logic              load_byte;
    logic [BYTE_W-1:0] in_buf;
    logic              ack_a;
    logic              ack_c;

    // A write while busy is dropped; the host must poll first
    assign load_byte = (wr_end && !busy_i) || fetch_go;

    always_ff @(posedge mclk) begin
        if (reset) begin
            in_full <= 1'b0;
            in_buf  <= '0;
        end else if (load_byte) begin
            in_full <= 1'b1;
            in_buf  <= fetch_go ? bus_s : cap;
        end else if (ack_b) begin
            in_full <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ack_a <= 1'b0;
            ack_b <= 1'b0;
        end else begin
            ack_a <= ack_c;
            ack_b <= ack_a;
        end
    end

    // Pin drivers, main clock
    logic err_flag;
    logic run;
    logic ser_mode;

    always_ff @(posedge mclk) begin
        if (reset) begin
            err_flag <= 1'b0;
        end else if (state == ST_CONFIG && err_s) begin
            err_flag <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            init_out <= 1'b0;
            init_oe  <= 1'b1;
        end else begin
            init_out <= 1'b0;
            init_oe  <= (state == ST_CLEAR)
                     || (err_flag && state == ST_CONFIG);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_active_high_flag    <= 1'b1;
            cfg_active_high_flag_oe <= 1'b1;
            cfg_active_low_flag     <= 1'b0;
            cfg_active_low_flag_oe  <= 1'b1;
            user_release            <= 1'b0;
        end else begin
            cfg_active_high_flag    <= 1'b1;
            cfg_active_high_flag_oe <= (state != ST_DONE);
            cfg_active_low_flag     <= 1'b0;
            cfg_active_low_flag_oe  <= (state != ST_DONE);
            user_release            <= (state == ST_DONE);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_byte_bus_out     <= '0;
            cfg_byte_bus_oe      <= 1'b0;
            ready_busy           <= 1'b1;
            memory_fetch_addr_oe <= 1'b0;
        end else begin
            cfg_byte_bus_out     <= {!busy_i, RD_STAT_LOW};
            cfg_byte_bus_oe      <= rd_act;
            ready_busy           <= !(busy_i || load_byte);
            memory_fetch_addr_oe <= mpar;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            run      <= 1'b0;
            ser_mode <= 1'b0;
        end else begin
            run      <= (state == ST_CONFIG);
            ser_mode <= (mode == MD_SLAVE_SER) || (mode == MD_MASTER_SER);
        end
    end

    // Link clock domain
    logic       rst_a;
    logic       rst_c;
    logic [2:0] lk_a;
    logic [2:0] lk_b;
    logic       req_c;
    logic       run_c;
    logic       ser_c;

    always_ff @(posedge cfg_clock) begin
        rst_a <= reset;
        rst_c <= rst_a;
    end

    always_ff @(posedge cfg_clock) begin
        if (rst_c) begin
            lk_a <= '0;
            lk_b <= '0;
        end else begin
            lk_a <= {in_full, run, ser_mode};
            lk_b <= lk_a;
        end
    end

    assign {req_c, run_c, ser_c} = lk_b;

    // Two-level converter: input buffer then this shifter
    logic [BYTE_W-1:0] sh;
    logic [2:0]        bit_i;
    logic              sh_full;
    logic              take;

    // Reload only once the previous byte is on its last bit
    assign take = req_c && !ack_c
               && (!sh_full || bit_i == LAST_BIT);

    always_ff @(posedge cfg_clock) begin
        if (rst_c) begin
            sh      <= '0;
            bit_i   <= '0;
            sh_full <= 1'b0;
            ack_c   <= 1'b0;
        end else begin
            if (take) begin
                sh      <= in_buf;
                bit_i   <= '0;
                sh_full <= 1'b1;
                ack_c   <= 1'b1;
            end else begin
                if (sh_full) begin
                    sh    <= sh >> 1;
                    bit_i <= bit_i + 1'b1;
                    if (bit_i == LAST_BIT) begin
                        sh_full <= 1'b0;
                    end
                end
                if (!req_c) begin
                    ack_c <= 1'b0;
                end
            end
        end
    end

    // Serial path
    logic din_q;
    logic dly_q;

    always_ff @(posedge cfg_clock) begin
        if (rst_c) begin
            din_q        <= 1'b0;
            dly_q        <= 1'b0;
            stream_bit   <= 1'b0;
            stream_valid <= 1'b0;
        end else begin
            din_q        <= serial_in;
            dly_q        <= ser_c ? din_q : sh[0];
            stream_bit   <= ser_c ? din_q : sh[0];
            stream_valid <= ser_c ? run_c : sh_full;
        end
    end

    // Half a period after the second rising edge
    always_ff @(negedge cfg_clock) begin
        if (rst_c) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out    <= dly_q;
            serial_out_oe <= run_c;
        end
    end

    // Checks, main clock
    a_sel_gate: assert property (@(posedge mclk) disable iff (reset)
        wr_act |-> (!sel_n_s && sel_h_s))
        else $error("write seen while not selected");

    a_write_capture: assert property (@(posedge mclk) disable iff (reset)
        (wr_end && !busy_i && periph) |=> (in_full && in_buf == $past(cap)))
        else $error("write end did not fill buffer");

    a_read_status: assert property (@(posedge mclk) disable iff (reset)
        rd_act |=> (cfg_byte_bus_oe
                    && cfg_byte_bus_out[STAT_BIT] == !$past(busy_i)
                    && cfg_byte_bus_out[6:0] == RD_STAT_LOW))
        else $error("read status wrong");

    a_write_wins: assert property (@(posedge mclk) disable iff (reset)
        (!ws_n_s && !rs_n_s) |=> !cfg_byte_bus_oe)
        else $error("bus driven during write");

    a_busy_hold: assert property (@(posedge mclk) disable iff (reset)
        load_byte |=> (!ready_busy && busy_i) [*2])
        else $error("busy too short after write");

    a_busy_match: assert property (@(posedge mclk) disable iff (reset)
        ready_busy |-> !$past(busy_i))
        else $error("ready while converter full");

    a_flag_high: assert property (@(posedge mclk) disable iff (reset)
        (state != ST_DONE) |=> (cfg_active_high_flag
                                && cfg_active_high_flag_oe))
        else $error("high flag dropped early");

    a_flag_low: assert property (@(posedge mclk) disable iff (reset)
        (state != ST_DONE) |=> (!cfg_active_low_flag
                                && cfg_active_low_flag_oe))
        else $error("low flag released early");

    a_init_clear: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_CLEAR) |=> init_oe)
        else $error("init not held during clear");

    a_wait_hold: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_WAIT && !init_s) |=> (state == ST_WAIT))
        else $error("left wait while init low");

    a_master_wait: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_HOLD && cnt < CNT_W'(MASTER_WAIT_CYC - 1))
        |=> (state != ST_CONFIG))
        else $error("master wait cut short");

    a_init_error: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_CONFIG && err_s) |-> ##2 init_oe)
        else $error("error not shown on init");

    a_addr_step: assert property (@(posedge mclk) disable iff (reset)
        fetch_go |=> (memory_fetch_addr == $past(memory_fetch_addr) + 1'b1))
        else $error("fetch address did not step");

    a_user_release: assert property (@(posedge mclk) disable iff (reset)
        (state == ST_DONE) |=> (user_release && !cfg_byte_bus_oe
                                && !memory_fetch_addr_oe))
        else $error("pins not released after done");

    // Checks, link clock; then covers on both clocks
    a_din_sample: assert property (@(posedge cfg_clock) disable iff (rst_c)
        ser_c && $past(ser_c) |-> (stream_bit == $past(din_q)))
        else $error("serial input not sampled");

    a_dout_delay: assert property (@(posedge cfg_clock) disable iff (rst_c)
        ser_c && $past(ser_c, 2) |-> ##1 (serial_out == $past(din_q)))
        else $error("serial output delay wrong");

    a_shift_step: assert property (@(posedge cfg_clock) disable iff (rst_c)
        (sh_full && !take) |=> (sh == ($past(sh) >> 1)))
        else $error("shifter did not advance");

    a_busy_bound: assert property (@(posedge cfg_clock) disable iff (rst_c)
        $rose(req_c) && !sh_full |-> ##[1:3] ack_c)
        else $error("empty converter held busy too long");

    c_periph_write: cover property (@(posedge mclk) disable iff (reset)
        load_byte && periph);
    c_back_to_back: cover property (@(posedge cfg_clock) disable iff (rst_c)
        take && sh_full);
    c_master_par: cover property (@(posedge mclk) disable iff (reset)
        fetch_go);
    c_done: cover property (@(posedge mclk) disable iff (reset)
        state == ST_DONE);

endmodule : fcp_loader
`default_nettype wire

// File: shared/fcp_pkg.sv
`default_nettype none
package fcp_pkg;
    localparam int MCLK_MHZ        = 50;
    localparam int WAIT_MIN_US     = 30;
    localparam int WAIT_MAX_US     = 300;
    // Least wait rounds up; whole microseconds give exact counts
    localparam int MASTER_WAIT_CYC = WAIT_MIN_US * MCLK_MHZ;
    localparam int WAIT_MAX_CYC    = WAIT_MAX_US * MCLK_MHZ;
    localparam int BUSY_MIN_CFG_CLOCK   = 2;
    localparam int BUSY_MAX_CFG_CLOCK   = 9;
    localparam int BYTE_W          = 8;
    localparam int ADDR_W          = 18;
    localparam int CNT_W           = 16;
    localparam int STAT_BIT        = 7;
    localparam logic [6:0] RD_STAT_LOW = 7'h00;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [7:0] SYNC_IDLE_LO = 8'h00;
    // Strobes and selects idle inactive, error and done idle low
    localparam logic [8:0] SYNC_IDLE_HI = 9'h160;
    typedef enum logic [1:0] {
        MD_SLAVE_SER,
        MD_MASTER_SER,
        MD_PERIPH,
        MD_MASTER_PAR
    } fcp_mode_t;
    typedef enum logic [2:0] {
        ST_CLEAR,
        ST_WAIT,
        ST_HOLD,
        ST_CONFIG,
        ST_DONE
    } fcp_state_t;
endpackage : fcp_pkg
`default_nettype wire

// File: bench/fcp_host.sv
`default_nettype none
module fcp_host (
    input  wire logic       mclk,
    input  wire logic       ready_busy,
    input  wire logic [7:0] bus_seen,
    output var  logic       select_low_n,
    output var  logic       select_high,
    output var  logic       write_strobe_n,
    output var  logic       read_strobe_n,
    output var  logic [7:0] bus_drive,
    output var  logic       bus_drive_en
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        select_low_n   = 1'b1;
        select_high    = 1'b0;
        write_strobe_n = 1'b1;
        read_strobe_n  = 1'b1;
        bus_drive      = 8'h00;
        bus_drive_en   = 1'b0;
    end

    task automatic write_byte(input logic [7:0] d, input logic sl_n,
                              input logic sh, input logic rd_too);
        int n;
        n = 0;
        while (ready_busy !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        select_low_n   = sl_n;
        select_high    = sh;
        bus_drive      = d;
        bus_drive_en   = 1'b1;
        write_strobe_n = 1'b0;
        read_strobe_n  = !rd_too;
        repeat (4) @(negedge mclk);
        write_strobe_n = 1'b1;
        read_strobe_n  = 1'b1;
        // Data held on: the pins cross two sync flops
        repeat (3) @(negedge mclk);
        select_low_n   = 1'b1;
        select_high    = 1'b0;
        bus_drive_en   = 1'b0;
    endtask : write_byte

    task automatic read_status(output logic [7:0] v);
        select_low_n  = 1'b0;
        select_high   = 1'b1;
        read_strobe_n = 1'b0;
        repeat (6) @(negedge mclk);
        v = bus_seen;
        read_strobe_n = 1'b1;
        select_low_n  = 1'b1;
        select_high   = 1'b0;
        repeat (5) @(negedge mclk);
    endtask : read_status
endmodule : fcp_host
`default_nettype wire

// File: bench/fcp_loader_test.sv
`default_nettype none
module fcp_loader_test;
    import fcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin \
    checks_done++; \
    if ((a) !== (b)) begin \
        bad_count++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
    logic        mclk = 1'b0, cfg_clock = 1'b0, reset = 1'b1;
    logic [1:0]  mode_pins = 2'h2;
    logic        ext_hold = 1'b0, cfg_error = 1'b0, cfg_complete = 1'b0;
    logic        serial_in = 1'b0, ser_on = 1'b0;
    logic [3:0]  ser_i = 4'h0;
    logic [15:0] ser_pat = 16'hb4e1;
    logic [1:0]  hist = 2'h0;
    logic        sl_n, sh, ws_n, rs_n, host_en, init_in, init_out, init_oe;
    logic [7:0]  host_d, bus_out, bus_in;
    logic        bus_oe, hf, hf_oe, lf, lf_oe, ready_busy, addr_oe;
    logic        serial_out, so_oe, stream_bit, stream_valid, user_release;
    logic [17:0] addr;
    logic        q_bits[$];
    int          busy_cyc = 0, bad_count = 0, checks_done = 0;

    always #10 mclk = ~mclk;
    // Link clock offset so its edges never line up with mclk
    initial begin
        #1.3;
        forever #3 cfg_clock = ~cfg_clock;
    end
    // Open-drain init with pull-up; bus pulled up when nobody drives
    assign init_in = (init_oe || ext_hold) ? 1'b0 : 1'b1;
    assign bus_in  = bus_oe ? bus_out : (host_en ? host_d : 8'hff);

    always @(posedge cfg_clock) if (stream_valid === 1'b1)
        q_bits.push_back(stream_bit);
    always @(posedge mclk) if (ready_busy === 1'b0) busy_cyc++;
    always @(posedge cfg_clock) hist <= {hist[0], serial_in};
    always @(negedge cfg_clock) if (ser_on) begin
        serial_in <= ser_pat[ser_i];
        ser_i     <= ser_i + 4'h1;
    end

    fcp_loader #(.CLEAR_CYCLES(4), .FETCH_WAIT(4)) i_fcp_loader (
        .mclk(mclk), .reset(reset), .cfg_clock(cfg_clock),
        .select_low_n(sl_n), .select_high(sh), .write_strobe_n(ws_n),
        .read_strobe_n(rs_n), .cfg_byte_bus_in(bus_in),
        .cfg_byte_bus_out(bus_out), .cfg_byte_bus_oe(bus_oe),
        .mode_pins(mode_pins), .init_in(init_in), .init_out(init_out),
        .init_oe(init_oe), .cfg_error(cfg_error),
        .cfg_complete(cfg_complete), .cfg_active_high_flag(hf),
        .cfg_active_high_flag_oe(hf_oe), .cfg_active_low_flag(lf),
        .cfg_active_low_flag_oe(lf_oe), .ready_busy(ready_busy),
        .memory_fetch_addr(addr), .memory_fetch_addr_oe(addr_oe),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(so_oe), .stream_bit(stream_bit),
        .stream_valid(stream_valid), .user_release(user_release));

    fcp_host i_fcp_host (
        .mclk(mclk), .ready_busy(ready_busy), .bus_seen(bus_in),
        .select_low_n(sl_n), .select_high(sh), .write_strobe_n(ws_n),
        .read_strobe_n(rs_n), .bus_drive(host_d), .bus_drive_en(host_en));

    task automatic end_sim;
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic do_reset(input logic [1:0] m, input logic hold);
        @(negedge mclk);
        reset     = 1'b1;
        mode_pins = m;
        ext_hold  = hold;
        repeat (6) @(negedge mclk);
        `CHK(init_oe, 1'b1)
        `CHK(init_out, 1'b0)
        `CHK({hf, hf_oe, lf, lf_oe}, 4'hd)
        `CHK({bus_oe, so_oe, addr_oe}, 3'h0)
        reset = 1'b0;
        // Clearing done, and init high unless hold is set, before any data is sent
        repeat (14) @(negedge mclk);
        q_bits.delete();
    endtask : do_reset

    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        while (q_bits.size() < 8 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        for (int i = 0; i < 8; i++)
            b[i] = (q_bits.size() > 0) ? q_bits.pop_front() : 1'bx;
    endtask : get_byte

    task automatic wr_timed(input logic [7:0] d, output int busy);
        int n;
        busy_cyc = 0;
        i_fcp_host.write_byte(d, 1'b0, 1'b1, 1'b0);
        n = 0;
        while (busy_cyc == 0 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (ready_busy !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        busy = busy_cyc;
    endtask : wr_timed

    task automatic t_write;
        int b;
        logic [7:0] got;
        logic [7:0] dat [3];
        dat = '{8'ha5, 8'h3c, 8'he1};
        do_reset(2'h2, 1'b0);
        // Back to back with no gap after ready
        foreach (dat[i]) begin
            wr_timed(dat[i], b);
            `CHK(b >= 1, 1'b1)
            `CHK(b <= 12, 1'b1)
        end
        foreach (dat[i]) begin
            get_byte(got);
            `CHK(got, dat[i])
        end
    endtask : t_write

    task automatic t_select;
        logic [1:0] sel [3];
        sel = '{2'h3, 2'h0, 2'h2};
        do_reset(2'h2, 1'b0);
        foreach (sel[i]) begin
            busy_cyc = 0;
            i_fcp_host.write_byte(8'h5a, sel[i][1], sel[i][0], 1'b0);
            repeat (30) @(negedge mclk);
            `CHK(q_bits.size(), 0)
            `CHK(busy_cyc, 0)
        end
    endtask : t_select

    task automatic t_read;
        logic [7:0] v;
        do_reset(2'h2, 1'b0);
        i_fcp_host.read_status(v);
        `CHK(v, 8'h80)
        // Device driving too would corrupt the streamed byte
        i_fcp_host.write_byte(8'hc3, 1'b0, 1'b1, 1'b1);
        get_byte(v);
        `CHK(v, 8'hc3)
    endtask : t_read

    task automatic t_init;
        int b;
        logic [7:0] got;
        do_reset(2'h2, 1'b1);
        `CHK(init_in, 1'b0)
        i_fcp_host.write_byte(8'h77, 1'b0, 1'b1, 1'b0);
        repeat (30) @(negedge mclk);
        `CHK(q_bits.size(), 0)
        ext_hold = 1'b0;
        repeat (14) @(negedge mclk);
        wr_timed(8'h77, b);
        get_byte(got);
        `CHK(got, 8'h77)
    endtask : t_init

    task automatic t_err_done;
        do_reset(2'h2, 1'b0);
        `CHK(init_oe, 1'b0)
        `CHK(user_release, 1'b0)
        cfg_error = 1'b1;
        repeat (4) @(negedge mclk);
        cfg_error = 1'b0;
        repeat (6) @(negedge mclk);
        `CHK(init_oe, 1'b1)
        do_reset(2'h2, 1'b0);
        cfg_complete = 1'b1;
        repeat (6) @(negedge mclk);
        `CHK(hf_oe, 1'b0)
        `CHK(lf_oe, 1'b0)
        `CHK(user_release, 1'b1)
        cfg_complete = 1'b0;
    endtask : t_err_done

    task automatic t_serial;
        do_reset(2'h0, 1'b0);
        ser_on = 1'b1;
        repeat (4) @(posedge cfg_clock);
        repeat (16) begin
            @(posedge cfg_clock);
            `CHK(stream_bit, hist[1])
            `CHK(serial_out, hist[1])
            `CHK(so_oe, 1'b1)
        end
        ser_on = 1'b0;
        @(negedge mclk);
    endtask : t_serial

    task automatic t_master;
        logic [17:0] a0;
        logic [1:0]  md [2];
        int          n;
        md = '{2'h1, 2'h3};
        // Master serial first, then master parallel
        foreach (md[i]) begin
            do_reset(md[i], 1'b0);
            repeat (1400) @(negedge mclk);
            `CHK({addr_oe, so_oe}, 2'h0)
            n = 0;
            while ((md[i][1] ? addr_oe : so_oe) !== 1'b1 && n < 200) begin
                @(negedge mclk);
                n++;
            end
            `CHK(md[i][1] ? addr_oe : so_oe, 1'b1)
            `CHK(addr_oe, md[i][1])
        end
        a0 = addr;
        `CHK(a0, 18'h0)
        repeat (40) @(negedge mclk);
        `CHK(addr > a0, 1'b1)
    endtask : t_master

    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        t_write();
        t_select();
        t_read();
        t_init();
        t_err_done();
        t_serial();
        t_master();
        end_sim();
    end
endmodule : fcp_loader_test
`default_nettype wire
